// ### rtl/tac_pkg.sv
// Package with register map, field layouts and mode codes of the timer channel block.
package tac_pkg;

  // ****************************************************************
  // Register byte offsets on the bus.
  // ****************************************************************
  localparam logic [7:0] OFF_RESET_CTRL  = 8'h00;
  localparam logic [7:0] OFF_CLOCK_EN    = 8'h04;
  localparam logic [7:0] OFF_PRESCALE    = 8'h08;
  localparam logic [7:0] OFF_MODE_CFG    = 8'h0c;
  localparam logic [7:0] OFF_COMPARE     = 8'h10;
  localparam logic [7:0] OFF_OUT_LEVEL   = 8'h14;
  localparam logic [7:0] OFF_OUT_EN      = 8'h18;
  localparam logic [7:0] OFF_START_STOP  = 8'h1c;
  localparam logic [7:0] OFF_COUNT_STAT  = 8'h20;
  localparam logic [7:0] OFF_IRQ_STATUS  = 8'h24;
  localparam logic [7:0] OFF_IRQ_CLEAR   = 8'h28;
  localparam logic [7:0] OFF_IRQ_ENABLE  = 8'h2c;

  // ****************************************************************
  // Bit positions and reset values.
  // ****************************************************************
  localparam int         UNIT_RESET_POS  = 0;
  localparam int         CLOCK_GATE_POS  = 0;
  localparam int         OUT_CH_POS      = 1;
  localparam int         START_POS       = 0;
  localparam int         STOP_POS        = 1;
  localparam int         RUNNING_POS     = 16;
  localparam int         IRQ_CH_POS      = 0;
  localparam logic [7:0]  RESET_CTRL_RST = 8'h00;
  localparam logic [7:0]  CLOCK_EN_RST   = 8'h00;
  localparam logic [15:0] PRESCALE_RST   = 16'h0000;
  localparam logic [15:0] MODE_CFG_RST   = 16'h0000;
  localparam logic [15:0] COMPARE_RST    = 16'h0000;
  localparam logic        OUT_LEVEL_RST  = 1'b0;
  localparam logic        OUT_EN_RST     = 1'b0;
  localparam logic [15:0] SPLIT_MASK     = 16'h00ff;
  localparam logic [15:0] FULL_MASK      = 16'hffff;

  // ****************************************************************
  // Field codes.
  // ****************************************************************
  localparam logic [2:0] MD_INTERVAL  = 3'h0;
  localparam logic [2:0] MD_CAPTURE   = 3'h2;
  localparam logic [2:0] MD_EVENT     = 3'h3;
  localparam logic [2:0] MD_ONE_COUNT = 3'h4;
  localparam logic [2:0] MD_CAP_ONE   = 3'h6;
  localparam logic [2:0] STS_SOFT     = 3'h0;
  localparam logic [2:0] STS_EDGE     = 3'h1;
  localparam logic [2:0] STS_BOTH     = 3'h2;
  localparam logic [2:0] STS_MASTER   = 3'h4;
  localparam logic [1:0] CIS_FALL     = 2'h0;
  localparam logic [1:0] CIS_RISE     = 2'h1;
  localparam logic [1:0] CIS_LOW_W    = 2'h2;
  localparam logic [1:0] CIS_HIGH_W   = 2'h3;

  // Decoded channel mode; prohibited codes fall into the last one.
  typedef enum {MODE_INTERVAL, MODE_CAPTURE, MODE_EVENT, MODE_ONE_COUNT, MODE_CAP_ONE, MODE_BAD} tac_mode_type;

  // Layout of the channel mode configuration register.
  typedef struct packed {
    logic [1:0] op_clock_select_field;
    logic       rsv13;
    logic       count_clock_source_bit;
    logic       width_split_bit;
    logic [2:0] start_trigger_field;
    logic [1:0] input_edge_field;
    logic [1:0] rsv5_4;
    logic [2:0] channel_mode_field;
    logic       start_behaviour_bit;
  } tac_mode_cfg_type;

  // Layout of the prescaler select register.
  typedef struct packed {
    logic [1:0] rsv15_14;
    logic [1:0] sel3;
    logic [1:0] rsv11_10;
    logic [1:0] sel2;
    logic [3:0] sel1;
    logic [3:0] prescale_select_field;
  } tac_prescale_type;

endpackage

// ### rtl/tac_timer_top.sv
// Timer unit channel 0 with prescaler, mode logic, output level and APB register file.
//
// Chosen here: the address map and the APB slave port.
`timescale 1ns/1ps
module tac_timer_top #(
  parameter int PRE_W = 15
) (
  // Clock and reset.
  input  wire logic        CLK,
  input  wire logic        RST_N,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  // Timer input pin and master channel interrupt.
  input  wire logic        TIMER_IN,
  input  wire logic        MASTER_INT,
  // Timer output level, channel interrupt pulse and interrupt line.
  output logic             TIMER_OUT,
  output logic             CH_INT,
  output logic             IRQ
);
  import tac_pkg::*;

  // ****************************************************************
  // Registers and internal signals.
  // ****************************************************************
  logic             unit_rst_reg, clk_en_reg;
  tac_prescale_type tps_reg;
  tac_mode_cfg_type tmr_reg;
  logic [15:0]      tdr_reg, cnt_reg, cnt_next;
  logic             out_reg, toe_reg, running_reg, run_next;
  logic             status_reg, status_next, irq_en_reg, irq_reg, ch_int_reg;
  logic             pready_reg, pslverr_reg;
  logic [31:0]      prdata_reg, rd_data;
  logic             rd_ok;
  logic [PRE_W-1:0] pre_reg;
  logic [3:0]       ck_tick;
  logic [3:0]       sel_field [4];
  logic             ti_s1_reg, ti_s2_reg, ti_s3_reg;
  logic             rise, fall, valid_edge, start_edge, cap_edge;
  logic             hw_start, cap_evt, sw_start, sw_stop, start_ok, restart_ok;
  logic             cnt_tick, fire_now, toggle_now, cap_now, unit_run, md0;
  logic [15:0]      mask, cnt_m, tdr_m;
  logic             wr_acc, setup_rd, blk_rst;
  tac_mode_type     mode;

  // Mask of low prescaler bits that must all be ones for a divided tick.
  function automatic logic [PRE_W-1:0] div_mask(input logic [3:0] n);
    div_mask = PRE_W'((32'h1 << n) - 32'h1);
  endfunction

  // Operation clock selection order is not binary: 01 picks clock 2, 10 picks clock 1.
  function automatic logic [1:0] op_index(input logic [1:0] sel);
    case (sel)
      2'h1:    op_index = 2'h2;
      2'h2:    op_index = 2'h1;
      default: op_index = sel;
    endcase
  endfunction

  // Mode decode from the upper three mode bits.
  function automatic tac_mode_type decode_mode(input logic [2:0] md);
    case (md)
      MD_INTERVAL:  decode_mode = MODE_INTERVAL;
      MD_CAPTURE:   decode_mode = MODE_CAPTURE;
      MD_EVENT:     decode_mode = MODE_EVENT;
      MD_ONE_COUNT: decode_mode = MODE_ONE_COUNT;
      MD_CAP_ONE:   decode_mode = MODE_CAP_ONE;
      default:      decode_mode = MODE_BAD;
    endcase
  endfunction

  // ****************************************************************
  // Unit control.
  // ****************************************************************
  // The channel logic moves only with the clock supplied and the unit out of reset.
  assign unit_run = clk_en_reg & ~unit_rst_reg;
  assign blk_rst  = ~RST_N | unit_rst_reg;
  assign wr_acc   = PSEL & PENABLE & PWRITE & pready_reg;
  assign setup_rd = PSEL & PENABLE & ~pready_reg;

  // Reset and clock gate bits stay writable so software can always release the unit.
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      unit_rst_reg <= RESET_CTRL_RST[UNIT_RESET_POS];
      clk_en_reg   <= CLOCK_EN_RST[CLOCK_GATE_POS];
    end else if (wr_acc) begin
      if (PADDR == OFF_RESET_CTRL) begin
        unit_rst_reg <= PWDATA[UNIT_RESET_POS];
      end else if (PADDR == OFF_CLOCK_EN) begin
        clk_en_reg <= PWDATA[CLOCK_GATE_POS];
      end
    end
  end

  // Unit registers only accept writes while the unit clock is supplied.
  always_ff @(posedge CLK) begin
    if (blk_rst) begin
      tps_reg <= PRESCALE_RST;
      tmr_reg <= MODE_CFG_RST;
      toe_reg <= OUT_EN_RST;
    end else if (wr_acc && clk_en_reg) begin
      if (PADDR == OFF_PRESCALE) begin
        tps_reg <= PWDATA[15:0];
      end else if (PADDR == OFF_MODE_CFG) begin
        tmr_reg <= PWDATA[15:0];
      end else if (PADDR == OFF_OUT_EN) begin
        toe_reg <= PWDATA[OUT_CH_POS];
      end
    end
  end

  // Compare data is also the capture register; a capture wins over a software write.
  always_ff @(posedge CLK) begin
    if (blk_rst) begin
      tdr_reg <= COMPARE_RST;
    end else if (cap_now) begin
      tdr_reg <= cnt_m;
    end else if (wr_acc && clk_en_reg && PADDR == OFF_COMPARE) begin
      tdr_reg <= PWDATA[15:0];
    end
  end

  // ****************************************************************
  // Prescaler.
  // ****************************************************************
  // Free running divider; each prescaled clock is a one-cycle tick.
  always_ff @(posedge CLK) begin
    if (blk_rst) begin
      pre_reg <= '0;
    end else if (unit_run) begin
      pre_reg <= pre_reg + PRE_W'(1);
    end
  end

  assign sel_field[0] = tps_reg.prescale_select_field;
  assign sel_field[1] = tps_reg.sel1;
  assign sel_field[2] = {2'h0, tps_reg.sel2};
  assign sel_field[3] = {2'h0, tps_reg.sel3};

  // Field value n gives one tick every 2**n system clocks; n of zero ticks every cycle.
  for (genvar k = 0; k < 4; k++) begin : g_tick
    assign ck_tick[k] = unit_run & (&(pre_reg | ~div_mask(sel_field[k])));
  end

  // ****************************************************************
  // Timer input synchroniser and edge selection.
  // ****************************************************************
  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      ti_s1_reg <= 1'b0;
      ti_s2_reg <= 1'b0;
      ti_s3_reg <= 1'b0;
    end else begin
      ti_s1_reg <= TIMER_IN;
      ti_s2_reg <= ti_s1_reg;
      ti_s3_reg <= ti_s2_reg;
    end
  end

  assign rise = ti_s2_reg & ~ti_s3_reg;
  assign fall = ~ti_s2_reg & ti_s3_reg;

  // Edge roles per input edge field.
  always_comb begin
    valid_edge = rise | fall;
    start_edge = rise | fall;
    cap_edge   = rise | fall;
    case (tmr_reg.input_edge_field)
      CIS_FALL: begin
        valid_edge = fall;
        start_edge = fall;
        cap_edge   = fall;
      end
      CIS_RISE: begin
        valid_edge = rise;
        start_edge = rise;
        cap_edge   = rise;
      end
      CIS_LOW_W: begin
        start_edge = fall;
        cap_edge   = rise;
      end
      default: begin
        start_edge = rise;
        cap_edge   = fall;
      end
    endcase
  end

  // Start and capture sources; prohibited trigger codes give no hardware trigger.
  always_comb begin
    hw_start = 1'b0;
    cap_evt  = 1'b0;
    case (tmr_reg.start_trigger_field)
      STS_EDGE: begin
        hw_start = valid_edge;
        cap_evt  = valid_edge;
      end
      STS_BOTH: begin
        hw_start = start_edge;
        cap_evt  = cap_edge;
      end
      STS_MASTER: hw_start = MASTER_INT;
      default: hw_start = 1'b0;
    endcase
  end

  // ****************************************************************
  // Channel counter.
  // ****************************************************************
  assign mode     = decode_mode(tmr_reg.channel_mode_field);
  assign md0      = tmr_reg.start_behaviour_bit;
  assign mask     = tmr_reg.width_split_bit ? SPLIT_MASK : FULL_MASK;
  assign cnt_m    = cnt_reg & mask;
  assign tdr_m    = tdr_reg & mask;
  assign cnt_tick = unit_run & (tmr_reg.count_clock_source_bit ? valid_edge
                    : ck_tick[op_index(tmr_reg.op_clock_select_field)]);
  assign sw_start = wr_acc & clk_en_reg & (PADDR == OFF_START_STOP) & PWDATA[START_POS];
  assign sw_stop  = wr_acc & clk_en_reg & (PADDR == OFF_START_STOP) & PWDATA[STOP_POS];
  // Restart while counting: software start in interval, capture and event modes; one-count only with the lowest mode bit set.
  assign restart_ok = (mode == MODE_ONE_COUNT) ? md0
                    : (sw_start & (mode != MODE_CAP_ONE));
  assign start_ok = unit_run & (sw_start | hw_start) & (~running_reg | restart_ok);

  // Next state of counter, run flag, interrupt and output toggle.
  // Holding the masked count drops stale upper bits once the channel is split to eight bits.
  always_comb begin
    cnt_next   = cnt_m;
    run_next   = running_reg;
    fire_now   = 1'b0;
    toggle_now = 1'b0;
    cap_now    = 1'b0;
    if (sw_stop) begin
      run_next = 1'b0;
    end else if (start_ok) begin
      run_next = 1'b1;
      case (mode)
        MODE_INTERVAL: begin
          cnt_next   = tdr_m;
          fire_now   = md0;
          toggle_now = md0;
        end
        MODE_CAPTURE: begin
          cnt_next   = 16'h0000;
          fire_now   = md0;
          toggle_now = md0;
        end
        MODE_EVENT, MODE_ONE_COUNT: cnt_next = tdr_m;
        MODE_CAP_ONE: cnt_next = 16'h0000;
        default: run_next = 1'b0;
      endcase
    end else if (running_reg && unit_run) begin
      case (mode)
        MODE_INTERVAL, MODE_EVENT, MODE_ONE_COUNT: begin
          if (cnt_tick && cnt_m == 16'h0000) begin
            fire_now   = 1'b1;
            toggle_now = (mode != MODE_EVENT);
            cnt_next   = tdr_m;
            run_next   = (mode != MODE_ONE_COUNT);
          end else if (cnt_tick) begin
            cnt_next = (cnt_m - 16'h0001) & mask;
          end
        end
        MODE_CAPTURE, MODE_CAP_ONE: begin
          if (cap_evt) begin
            cap_now    = 1'b1;
            fire_now   = 1'b1;
            toggle_now = (mode == MODE_CAP_ONE);
            cnt_next   = 16'h0000;
            run_next   = (mode == MODE_CAPTURE);
          end else if (cnt_tick) begin
            cnt_next = (cnt_m + 16'h0001) & mask;
          end
        end
        default: run_next = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK) begin
    if (blk_rst) begin
      cnt_reg     <= 16'h0000;
      running_reg <= 1'b0;
      ch_int_reg  <= 1'b0;
    end else begin
      cnt_reg     <= cnt_next;
      running_reg <= run_next;
      ch_int_reg  <= fire_now;
    end
  end

  // ****************************************************************
  // Timer output level.
  // ****************************************************************
  // With output enabled only the timer moves the level, so software cannot glitch the pin.
  always_ff @(posedge CLK) begin
    if (blk_rst) begin
      out_reg <= OUT_LEVEL_RST;
    end else if (toe_reg) begin
      if (toggle_now) begin
        out_reg <= ~out_reg;
      end
    end else if (wr_acc && clk_en_reg && PADDR == OFF_OUT_LEVEL) begin
      out_reg <= PWDATA[OUT_CH_POS];
    end
  end

  // ****************************************************************
  // Interrupt status, enable and line.
  // ****************************************************************
  // A new event in the clearing cycle keeps the bit set.
  assign status_next = fire_now | (status_reg & ~(wr_acc && PADDR == OFF_IRQ_CLEAR && PWDATA[IRQ_CH_POS]));

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      status_reg <= 1'b0;
      irq_en_reg <= 1'b0;
      irq_reg    <= 1'b0;
    end else begin
      status_reg <= status_next;
      irq_reg    <= status_reg & irq_en_reg;
      if (wr_acc && PADDR == OFF_IRQ_ENABLE) begin
        irq_en_reg <= PWDATA[IRQ_CH_POS];
      end
    end
  end

  // ****************************************************************
  // APB read path: one wait state, data and error registered.
  // ****************************************************************
  always_comb begin
    rd_data = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (PADDR == OFF_RESET_CTRL) begin
      rd_data[UNIT_RESET_POS] = unit_rst_reg;
    end else if (PADDR == OFF_CLOCK_EN) begin
      rd_data[CLOCK_GATE_POS] = clk_en_reg;
    end else if (PADDR == OFF_PRESCALE) begin
      rd_data[15:0] = tps_reg;
    end else if (PADDR == OFF_MODE_CFG) begin
      rd_data[15:0] = tmr_reg;
    end else if (PADDR == OFF_COMPARE) begin
      rd_data[15:0] = tdr_reg;
    end else if (PADDR == OFF_OUT_LEVEL) begin
      rd_data[OUT_CH_POS] = out_reg;
    end else if (PADDR == OFF_OUT_EN) begin
      rd_data[OUT_CH_POS] = toe_reg;
    end else if (PADDR == OFF_COUNT_STAT) begin
      rd_data[15:0]        = cnt_reg;
      rd_data[RUNNING_POS] = running_reg;
    end else if (PADDR == OFF_IRQ_STATUS) begin
      rd_data[IRQ_CH_POS] = status_reg;
    end else if (PADDR == OFF_IRQ_ENABLE) begin
      rd_data[IRQ_CH_POS] = irq_en_reg;
    end else if (PADDR != OFF_START_STOP && PADDR != OFF_IRQ_CLEAR) begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      pready_reg  <= 1'b0;
      prdata_reg  <= 32'h0000_0000;
      pslverr_reg <= 1'b0;
    end else begin
      pready_reg  <= setup_rd;
      prdata_reg  <= (setup_rd && !PWRITE) ? rd_data : 32'h0000_0000;
      pslverr_reg <= setup_rd & ~rd_ok;
    end
  end

  assign PREADY    = pready_reg;
  assign PRDATA    = prdata_reg;
  assign PSLVERR   = pslverr_reg;
  assign TIMER_OUT = out_reg;
  assign CH_INT    = ch_int_reg;
  assign IRQ       = irq_reg;

  // ****************************************************************
  // Assertions.
  // ****************************************************************
  sequence s_interval_wrap;
    running_reg && !start_ok && !sw_stop && mode == MODE_INTERVAL && cnt_tick && cnt_m == 16'h0000;
  endsequence

  sequence s_reload_seen;
    ch_int_reg && cnt_reg == $past(tdr_m);
  endsequence

  chk_unit_reset_hold: assert property (@(posedge CLK) disable iff (!RST_N)
    unit_rst_reg |=> cnt_reg == 16'h0000 && !running_reg && !ch_int_reg)
    else $error("counter not held while unit reset bit set");
  chk_clock_gate_stop: assert property (@(posedge CLK) disable iff (!RST_N)
    !clk_en_reg && !unit_rst_reg |=> $stable(cnt_reg) && !ch_int_reg)
    else $error("counter moved with unit clock gated");
  chk_prescale_div: assert property (@(posedge CLK) disable iff (!RST_N)
    unit_run && tps_reg.prescale_select_field == 4'h1 && ck_tick[0] && $stable(tps_reg) |=> !ck_tick[0])
    else $error("divide by two tick in back to back cycles");
  chk_opclk_select: assert property (@(posedge CLK) disable iff (!RST_N)
    unit_run && !tmr_reg.count_clock_source_bit && tmr_reg.op_clock_select_field == 2'h1 |-> cnt_tick == ck_tick[2])
    else $error("select 01 did not pick prescaled clock 2");
  chk_pin_count: assert property (@(posedge CLK) disable iff (!RST_N)
    unit_run && tmr_reg.count_clock_source_bit |-> cnt_tick == valid_edge)
    else $error("pin count source does not follow valid edges");
  chk_split_width: assert property (@(posedge CLK) disable iff (!RST_N)
    tmr_reg.width_split_bit && (cnt_tick || start_ok) |=> cnt_reg[15:8] == 8'h00)
    else $error("split channel counter exceeded eight bits");
  chk_interval_reload: assert property (@(posedge CLK) disable iff (blk_rst)
    s_interval_wrap |=> s_reload_seen)
    else $error("interval underflow without reload and interrupt");
  chk_start_irq: assert property (@(posedge CLK) disable iff (blk_rst)
    start_ok && !sw_stop && (mode == MODE_INTERVAL || mode == MODE_CAPTURE) |=> ch_int_reg == $past(md0))
    else $error("start interrupt disagrees with lowest mode bit");
  chk_oneshot_ignore: assert property (@(posedge CLK) disable iff (blk_rst)
    running_reg && mode == MODE_ONE_COUNT && !md0 && hw_start && !sw_start && !sw_stop && !cnt_tick
    |=> $stable(cnt_reg) && !ch_int_reg)
    else $error("one-count restarted while counting");
  chk_out_sw_ignore: assert property (@(posedge CLK) disable iff (blk_rst)
    toe_reg && !toggle_now && wr_acc && PADDR == OFF_OUT_LEVEL |=> $stable(out_reg))
    else $error("software write moved enabled timer output");

endmodule // tac_timer_top

// ### dv/tac_timer_top_tb.sv
// Self-checking testbench of the timer channel block over its APB register port.
`timescale 1ns/1ps
module tac_timer_top_tb;
  import tac_pkg::*;
  // ****************************************************************
  // Stimulus signals and bookkeeping.
  // ****************************************************************
  logic        clk      = 1'b0;
  logic        rst_n    = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [7:0]  paddr    = 8'h00;
  logic [31:0] pwdata   = 32'h0;
  logic        timer_in   = 1'b0;
  logic        master_int = 1'b0;
  logic        pready, pslverr, timer_out, ch_int, irq, err_seen, hit, lvl;
  logic [31:0] prdata, rd;
  int          n_fail   = 0;
  int          n_checks = 0;
  int          per;
  // Period table: prescaler, mode, compare and expected cycles between interrupts.
  logic [15:0] t_pre[5] = '{16'h0000, 16'h0002, 16'h0011, 16'h0100, 16'h0000};
  logic [15:0] t_md[5]  = '{16'h0000, 16'h0000, 16'h8000, 16'h4000, 16'h0800};
  logic [15:0] t_cmp[5] = '{16'h0004, 16'h0004, 16'h0004, 16'h0002, 16'h0103};
  int          t_exp[5] = '{5, 20, 10, 6, 4};

  // Timer pin and master interrupt idle low until the pin count and master start tests.
  tac_timer_top #(.PRE_W(15)) i_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PREADY(pready), .PRDATA(prdata),
    .PSLVERR(pslverr), .TIMER_IN(timer_in), .MASTER_INT(master_int), .TIMER_OUT(timer_out),
    .CH_INT(ch_int), .IRQ(irq));

  // The 40 MHz system clock.
  always #12.5 clk = ~clk;

  // ****************************************************************
  // Shared tasks.
  // ****************************************************************
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One APB transfer; the request is held until pready is sampled high, and only the watchdog ends a wait.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd       = prdata;
    err_seen = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Stops the channel, loads a new setup and starts it by software.
  task automatic run(input logic [15:0] pre, input logic [15:0] md, input logic [15:0] cmp);
    apb(1'b1, OFF_START_STOP, 32'h2);
    apb(1'b1, OFF_PRESCALE, {16'h0, pre});
    apb(1'b1, OFF_MODE_CFG, {16'h0, md});
    apb(1'b1, OFF_COMPARE, {16'h0, cmp});
    apb(1'b1, OFF_START_STOP, 32'h1);
  endtask

  // Counts cycles between two interrupt pulses; bounded so a silent channel cannot hang.
  task automatic measure(output int p);
    int i;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (ch_int !== 1'b1 && i < 2000);
    p = 0;
    do begin
      @(posedge clk);
      p++;
    end while (ch_int !== 1'b1 && p < 2000);
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic print_verdict();
    $display("checks %0d failures %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // ****************************************************************
  // Test sequence.
  // ****************************************************************
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b1, OFF_COMPARE, 32'h5);
    apb(1'b0, OFF_COMPARE, 32'h0);
    chk("compare while gated", 32'h0, rd);
    apb(1'b0, 8'h30, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err_seen});
    apb(1'b1, OFF_CLOCK_EN, 32'h1);
    apb(1'b1, OFF_COMPARE, 32'h5);
    apb(1'b1, OFF_RESET_CTRL, 32'h1);
    apb(1'b1, OFF_RESET_CTRL, 32'h0);
    apb(1'b0, OFF_COMPARE, 32'h0);
    chk("compare after unit reset", 32'h0, rd);
    // With the output disabled, software owns the level and the timer leaves it alone.
    apb(1'b1, OFF_OUT_LEVEL, 32'h2);
    @(posedge clk);
    chk("output level pin", 32'h1, {31'h0, timer_out});
    for (int k = 0; k < 5; k++) begin
      run(t_pre[k], t_md[k], t_cmp[k]);
      measure(per);
      chk("interrupt period", t_exp[k], per);
    end
    chk("level kept by timer", 32'h1, {31'h0, timer_out});
    // Status is sticky and masked until enabled, then cleared by a write of one.
    apb(1'b1, OFF_START_STOP, 32'h2);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    chk("status sticky", 32'h1, rd);
    chk("irq masked", 32'h0, {31'h0, irq});
    apb(1'b1, OFF_IRQ_ENABLE, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq enabled", 32'h1, {31'h0, irq});
    apb(1'b1, OFF_IRQ_CLEAR, 32'h1);
    repeat (2) @(posedge clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    // Start interrupt follows the lowest mode bit in interval mode.
    for (int b = 0; b < 2; b++) begin
      run(16'h0000, {15'h0, b[0]}, 16'h0100);
      hit = 1'b0;
      repeat (6) begin
        @(posedge clk);
        hit = hit | ch_int;
      end
      chk("start interrupt", b, {31'h0, hit});
    end
    // Timer owns the level once enabled: writes ignored, level toggles per interrupt.
    apb(1'b1, OFF_OUT_EN, 32'h2);
    apb(1'b1, OFF_OUT_LEVEL, 32'h0);
    apb(1'b0, OFF_OUT_LEVEL, 32'h0);
    chk("level write ignored", 32'h2, rd & 32'h2);
    run(16'h0000, 16'h0000, 16'h0004);
    measure(per);
    @(posedge clk);
    lvl = timer_out;
    chk("toggle period", 32'd5, per);
    // The next interrupt lands five cycles after the last one; exactly one toggle is due by then.
    repeat (5) @(posedge clk);
    chk("output toggle", {31'h0, ~lvl}, {31'h0, timer_out});
    // One-count mode stops at zero; the count reloads from compare but does not run on.
    run(16'h0000, 16'h0008, 16'h0003);
    repeat (20) @(posedge clk);
    apb(1'b0, OFF_COUNT_STAT, 32'h0);
    chk("one-count stopped", 32'h0, {31'h0, rd[RUNNING_POS]});
    // Event counter on rising pin edges: two pulses take compare 2 down to zero, falls are ignored.
    run(16'h0000, 16'h1046, 16'h0002);
    repeat (2) begin
      timer_in <= 1'b1;
      repeat (4) @(posedge clk);
      timer_in <= 1'b0;
      repeat (4) @(posedge clk);
    end
    apb(1'b0, OFF_COUNT_STAT, 32'h0);
    chk("pin event count", 32'h0001_0000, rd);
    // A master channel pulse starts the channel when the trigger field selects it.
    apb(1'b1, OFF_START_STOP, 32'h2);
    apb(1'b1, OFF_MODE_CFG, 32'h0400);
    master_int <= 1'b1;
    @(posedge clk);
    master_int <= 1'b0;
    apb(1'b0, OFF_COUNT_STAT, 32'h0);
    chk("master start", 32'h1, {31'h0, rd[RUNNING_POS]});
    print_verdict();
  end

  // Watchdog: the sequence needs a few hundred cycles, so the 30000 cycle limit lies well above it and only a hang reaches it.
  initial begin
    repeat (30000) @(posedge clk);
    n_fail++;
    print_verdict();
  end
endmodule // tac_timer_top_tb
